// ---- verilog/drive_bus_data_map.sv ----
/*
 * Coil and holding register map of the drive as seen by the bus master.
 * Assumes the serial slave in front of it has framed the message, checked
 * it, handled the function code and turned it into one-cycle coil and
 * register requests with zero-based addresses, on the same clock.
 */
// How it works
// RULE_01 - coils are bits, registers 16-bit words
// RULE_02 - coil addresses are coil number minus one
// RULE_03 - register addresses drop the 4xxxx prefix
// RULE_04 - coils 1-16 hold the control word
// RULE_05 - coils 17-32 hold the speed reference
// RULE_06 - coils 33-48 show the status word
// RULE_07 - cleared coils 3-6 request stops; 7 starts
// RULE_08 - coil 65 selects RAM or RAM plus EEPROM
// RULE_09 - status coils 33-35 show readiness and safety
// RULE_10 - coils 46-48 follow voltage, current, thermal
// RULE_11 - register 7 returns last error code
// RULE_12 - register 9 holds the array index
// RULE_13 - parameters sit at ten times number
// RULE_14 - register 50000 takes the control word
// RULE_15 - register 50010 takes the bus reference
// RULE_16 - register 50200 returns the status word
// RULE_17 - register 50210 returns main actual value
// RULE_18 - reserved places read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "drive_bus_data_map_cfg.svh"

module drive_bus_data_map
   import drive_bus_data_map_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   // coil access from the serial slave
   input wire logic i_coil_req,
   input wire logic i_coil_we,
   input wire logic [15:0] i_coil_addr,
   input wire logic i_coil_wdata,
   output logic o_coil_ack,
   output logic o_coil_rdata,
   // holding register access from the serial slave
   input wire logic i_reg_req,
   input wire logic i_reg_we,
   input wire logic [15:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic o_reg_ack,
   output logic [15:0] o_reg_rdata,
   output logic o_reg_busy,
   // parameter store
   output logic o_param_req,
   output logic o_param_we,
   output logic [15:0] o_param_num,
   output logic [15:0] o_param_wdata,
   output logic [15:0] o_param_index,
   output logic o_store_eeprom,
   input wire logic i_param_ack,
   input wire logic [15:0] i_param_rdata,
   // drive state
   input wire logic i_error_strobe,
   input wire logic [15:0] i_error_code,
   input wire logic [15:0] i_main_actual,
   input wire logic i_control_ready,
   input wire logic i_drive_ready,
   input wire logic i_safety_closed,
   input wire logic i_alarm,
   input wire logic i_warning,
   input wire logic i_at_reference,
   input wire logic i_auto_mode,
   input wire logic i_in_freq_range,
   input wire logic i_running,
   input wire logic i_voltage_warning,
   input wire logic i_current_limit,
   input wire logic i_thermal_warning,
   // control word and reference towards the drive
   output logic [15:0] o_control_word,
   output logic [15:0] o_speed_reference,
   output logic [1:0] o_preset_ref,
   output logic o_dc_brake_req,
   output logic o_coast_req,
   output logic o_quick_stop_req,
   output logic o_freeze_req,
   output logic o_start,
   output logic o_reset_req,
   output logic o_jog,
   output logic o_ramp2,
   output logic o_data_valid,
   output logic o_relay1,
   output logic o_relay2,
   output logic [1:0] o_setup_sel,
   output logic o_reverse
);
   // ========================================================================
   // shared helpers
   // ========================================================================
   // every check runs on the one clock and sleeps through reset
   default clocking chk_clk @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   // a coil write wins over a same-cycle register write of the same word
   function automatic logic field_bit_next(input logic cur, coil_hit,
      coil_bit, reg_hit, reg_bit);
      field_bit_next = coil_hit ? coil_bit : (reg_hit ? reg_bit : cur);
   endfunction : field_bit_next

   // ========================================================================
   // address decode
   // ========================================================================
   logic sel_coil_ctw, sel_coil_ref, sel_coil_stw, sel_coil_mav;
   logic sel_coil_store;
   logic sel_err, sel_idx, sel_ctw, sel_ref, sel_stw, sel_mav, sel_param;
   logic [15:0] param_num;

   map_addr_decode u_decode (
      .i_coil_addr(i_coil_addr),
      .i_reg_addr(i_reg_addr),
      .o_coil_ctw(sel_coil_ctw),
      .o_coil_ref(sel_coil_ref),
      .o_coil_stw(sel_coil_stw),
      .o_coil_mav(sel_coil_mav),
      .o_coil_store(sel_coil_store),
      .o_reg_err(sel_err),
      .o_reg_idx(sel_idx),
      .o_reg_ctw(sel_ctw),
      .o_reg_ref(sel_ref),
      .o_reg_stw(sel_stw),
      .o_reg_mav(sel_mav),
      .o_reg_param(sel_param),
      .o_param_num(param_num)
   );

   // ========================================================================
   // state
   // ========================================================================
   access_state_t state_reg, state_next; // register sequencer
   word_t ctw_reg, ctw_next; // control word
   word_t ref_reg, ref_next; // speed reference
   word_t stw_reg, stw_next; // status word snapshot
   word_t mav_reg; // main actual value snapshot
   word_t err_reg; // last error code
   word_t idx_reg; // array index
   logic store_reg; // storage target coil

   wire idle = state_reg == ACC_IDLE;
   wire coil_wr = i_coil_req & i_coil_we;
   // register requests are only taken while idle; busy shows the refusal
   wire reg_take = i_reg_req & idle;
   wire reg_wr = reg_take & i_reg_we;
   wire [3:0] coil_bit = i_coil_addr[`COIL_BIT_MSB:0];
   wire param_take = reg_take & sel_param;   // [RULE_13]
   wire param_done = (state_reg == ACC_PARAM) & i_param_ack;

   // ========================================================================
   // control word and reference: coils and registers share one store
   // ========================================================================
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_field
         wire coil_here = coil_wr & (coil_bit == 4'(gi));
         assign ctw_next[gi] = field_bit_next(ctw_reg[gi],
            coil_here & sel_coil_ctw, i_coil_wdata,
            reg_wr & sel_ctw, i_reg_wdata[gi]);   // [RULE_04] [RULE_14]
         assign ref_next[gi] = field_bit_next(ref_reg[gi],
            coil_here & sel_coil_ref, i_coil_wdata,
            reg_wr & sel_ref, i_reg_wdata[gi]);   // [RULE_05] [RULE_15]
      end
   endgenerate

   // ========================================================================
   // status word assembly; unused coils stay zero
   // ========================================================================
   always_comb begin
      stw_next = `WORD_RESET;
      stw_next[`STW_CTRL_READY] = i_control_ready; // [RULE_09]
      stw_next[`STW_DRIVE_READY] = i_drive_ready; // [RULE_09]
      stw_next[`STW_SAFETY] = i_safety_closed; // [RULE_09]
      stw_next[`STW_ALARM] = i_alarm; // [RULE_06]
      stw_next[`STW_WARNING] = i_warning; // [RULE_06]
      stw_next[`STW_AT_REF] = i_at_reference; // [RULE_06]
      stw_next[`STW_AUTO] = i_auto_mode; // [RULE_06]
      stw_next[`STW_IN_RANGE] = i_in_freq_range; // [RULE_06]
      stw_next[`STW_RUNNING] = i_running; // [RULE_06]
      stw_next[`STW_VOLTAGE] = i_voltage_warning; // [RULE_10]
      stw_next[`STW_CURRENT] = i_current_limit; // [RULE_10]
      stw_next[`STW_THERMAL] = i_thermal_warning; // [RULE_10]
   end

   // ========================================================================
   // read multiplexers; anything not decoded reads zero
   // ========================================================================
   wire coil_rdata_next =
      sel_coil_ctw ? ctw_reg[coil_bit] :
      sel_coil_ref ? ref_reg[coil_bit] :
      sel_coil_stw ? stw_reg[coil_bit] :
      sel_coil_mav ? mav_reg[coil_bit] :
      sel_coil_store ? store_reg : `BIT_RESET;   // [RULE_01] [RULE_18]

   wire [15:0] reg_rdata_next =
      param_done ? i_param_rdata :
      sel_err ? err_reg : // [RULE_11]
      sel_idx ? idx_reg :
      sel_ctw ? ctw_reg :
      sel_ref ? ref_reg :
      sel_stw ? stw_reg : // [RULE_16]
      sel_mav ? mav_reg : `WORD_RESET; // [RULE_17] [RULE_18]

   // ========================================================================
   // sequencer: parameter accesses wait for the store, others answer next
   // ========================================================================
   always_comb begin
      case (state_reg)
         ACC_IDLE: begin
            state_next = param_take ? ACC_PARAM : ACC_IDLE;
         end
         ACC_PARAM: begin
            state_next = i_param_ack ? ACC_IDLE : ACC_PARAM;
         end
         default: begin
            state_next = ACC_IDLE;
         end
      endcase
   end

   wire reg_ack_next = (reg_take & ~sel_param) | param_done;

   // ========================================================================
   // storage flops
   // ========================================================================
   // the status word and main actual value are captured every cycle so the outputs stay registered
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= ACC_IDLE;
         ctw_reg <= `WORD_RESET;
         ref_reg <= `WORD_RESET;
         stw_reg <= `WORD_RESET;
         mav_reg <= `WORD_RESET;
         err_reg <= `WORD_RESET;
         idx_reg <= `WORD_RESET;
         store_reg <= `BIT_RESET;
      end else begin
         state_reg <= state_next;
         ctw_reg <= ctw_next;
         ref_reg <= ref_next;
         stw_reg <= stw_next;
         mav_reg <= i_main_actual;
         if (i_error_strobe) begin
            err_reg <= i_error_code; // [RULE_11]
         end
         if (reg_wr & sel_idx) begin
            idx_reg <= i_reg_wdata; // [RULE_12]
         end
         if (coil_wr & sel_coil_store) begin
            store_reg <= i_coil_wdata; // [RULE_08]
         end
      end
   end

   // bus answers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_coil_ack <= `BIT_RESET;
         o_coil_rdata <= `BIT_RESET;
         o_reg_ack <= `BIT_RESET;
         o_reg_rdata <= `WORD_RESET;
         o_reg_busy <= `BIT_RESET;
      end else begin
         o_coil_ack <= i_coil_req;
         o_coil_rdata <= i_coil_req ? coil_rdata_next : `BIT_RESET;
         o_reg_ack <= reg_ack_next;
         o_reg_rdata <= reg_ack_next ? reg_rdata_next : `WORD_RESET;
         o_reg_busy <= state_next == ACC_PARAM;
      end
   end

   // parameter store request
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_param_req <= `BIT_RESET;
         o_param_we <= `BIT_RESET;
         o_param_num <= `WORD_RESET;
         o_param_wdata <= `WORD_RESET;
      end else begin
         o_param_req <= param_take; // [RULE_13]
         if (param_take) begin
            o_param_we <= i_reg_we;
            o_param_num <= param_num;
            o_param_wdata <= i_reg_wdata;
         end
      end
   end

   // decoded control outputs follow the word one cycle later
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_preset_ref <= 2'h0;
         o_dc_brake_req <= `BIT_RESET;
         o_coast_req <= `BIT_RESET;
         o_quick_stop_req <= `BIT_RESET;
         o_freeze_req <= `BIT_RESET;
         o_start <= `BIT_RESET;
         o_reset_req <= `BIT_RESET;
         o_jog <= `BIT_RESET;
         o_ramp2 <= `BIT_RESET;
         o_data_valid <= `BIT_RESET;
         o_relay1 <= `BIT_RESET;
         o_relay2 <= `BIT_RESET;
         o_setup_sel <= 2'h0;
         o_reverse <= `BIT_RESET;
      end else begin
         o_preset_ref <= ctw_reg[`CTW_PRESET_MSB:`CTW_PRESET_LSB];
         o_dc_brake_req <= ~ctw_reg[`CTW_DC_BRAKE];    // [RULE_07]
         o_coast_req <= ~ctw_reg[`CTW_COAST];          // [RULE_07]
         o_quick_stop_req <= ~ctw_reg[`CTW_QUICK_STOP];// [RULE_07]
         o_freeze_req <= ~ctw_reg[`CTW_FREEZE];        // [RULE_07]
         o_start <= ctw_reg[`CTW_START];               // [RULE_07]
         o_reset_req <= ctw_reg[`CTW_RESET];
         o_jog <= ctw_reg[`CTW_JOG];
         o_ramp2 <= ctw_reg[`CTW_RAMP2];
         o_data_valid <= ctw_reg[`CTW_DATA_VALID];
         o_relay1 <= ctw_reg[`CTW_RELAY1];
         o_relay2 <= ctw_reg[`CTW_RELAY2];
         o_setup_sel <= ctw_reg[`CTW_SETUP_MSB:`CTW_SETUP_LSB];
         o_reverse <= ctw_reg[`CTW_REVERSE];
      end
   end

   assign o_control_word = ctw_reg;
   assign o_speed_reference = ref_reg;
   assign o_param_index = idx_reg;
   assign o_store_eeprom = store_reg;

   // ========================================================================
   // checks
   // ========================================================================
   ctw_coil_write_a: assert property ( // [RULE_04]
      coil_wr && sel_coil_ctw |=>
         o_control_word[$past(coil_bit)] == $past(i_coil_wdata))
      else $error("control coil write lost");
   ctw_reg_write_a: assert property ( // [RULE_14]
      reg_wr && sel_ctw && !coil_wr |=>
         o_control_word == $past(i_reg_wdata))
      else $error("control word register write lost");
   ref_reg_write_a: assert property ( // [RULE_15]
      reg_wr && sel_ref && !coil_wr |=>
         o_speed_reference == $past(i_reg_wdata))
      else $error("bus reference write lost");
   brake_decode_a: assert property ( // [RULE_07]
      $past(i_reset_n) |->
         o_dc_brake_req == !$past(o_control_word[`CTW_DC_BRAKE]))
      else $error("brake request not the inverted coil");
   store_coil_a: assert property ( // [RULE_08]
      coil_wr && sel_coil_store |=> o_store_eeprom == $past(i_coil_wdata))
      else $error("storage coil not updated");
   index_write_a: assert property ( // [RULE_12]
      reg_wr && sel_idx |=> o_param_index == $past(i_reg_wdata))
      else $error("array index not stored");
   status_read_a: assert property ( // [RULE_16]
      reg_take && !i_reg_we && sel_stw |=> o_reg_ack &&
         o_reg_rdata[`STW_THERMAL] == $past(i_thermal_warning, 2))
      else $error("status word read wrong");
   reserved_coil_a: assert property ( // [RULE_18]
      i_coil_req && i_coil_addr > `COIL_STORE |=>
         o_coil_ack && !o_coil_rdata)
      else $error("reserved coil not zero");
   param_req_a: assert property ( // [RULE_13]
      param_take |=> o_param_req && o_reg_busy && !o_reg_ack &&
         o_param_num == $past(i_reg_addr) / `PARAM_STEP)
      else $error("parameter request wrong");
endmodule : drive_bus_data_map

`default_nettype wire

// ---- inc/drive_bus_data_map_cfg.svh ----
/*
 * Address map, field positions and reset values of the drive bus data map.
 * Assumes it is included by bare name, after the package, by design files.
 */
`ifndef DRIVE_BUS_DATA_MAP_CFG_SVH
`define DRIVE_BUS_DATA_MAP_CFG_SVH

// ==========================================================================
// coil space (zero-based message addresses)
// ==========================================================================
`define COIL_CTW_BASE 16'h0000
`define COIL_REF_BASE 16'h0010
`define COIL_STW_BASE 16'h0020
`define COIL_MAV_BASE 16'h0030
`define COIL_STORE 16'h0040
`define COIL_FIELD_MASK 16'hfff0
`define COIL_BIT_MSB 3

// ==========================================================================
// holding register space (message addresses)
// ==========================================================================
`define REG_LAST_ERROR 16'h0007
`define REG_ARRAY_INDEX 16'h0009
`define REG_CTW 16'hc350
`define REG_REF 16'hc35a
`define REG_STW 16'hc418
`define REG_MAV 16'hc422
`define PARAM_ADDR_MIN 16'h000a
`define PARAM_ADDR_MAX 16'hc346
`define PARAM_STEP 16'h000a
`define PARAM_REM_ZERO 16'h0000

// ==========================================================================
// control word bit positions (coil n is bit n-1)
// ==========================================================================
`define CTW_PRESET_LSB 0
`define CTW_PRESET_MSB 1
`define CTW_DC_BRAKE 2
`define CTW_COAST 3
`define CTW_QUICK_STOP 4
`define CTW_FREEZE 5
`define CTW_START 6
`define CTW_RESET 7
`define CTW_JOG 8
`define CTW_RAMP2 9
`define CTW_DATA_VALID 10
`define CTW_RELAY1 11
`define CTW_RELAY2 12
`define CTW_SETUP_LSB 13
`define CTW_SETUP_MSB 14
`define CTW_REVERSE 15

// ==========================================================================
// status word bit positions (coil 33 is bit 0)
// ==========================================================================
`define STW_CTRL_READY 0
`define STW_DRIVE_READY 1
`define STW_SAFETY 2
`define STW_ALARM 3
`define STW_WARNING 7
`define STW_AT_REF 8
`define STW_AUTO 9
`define STW_IN_RANGE 10
`define STW_RUNNING 11
`define STW_VOLTAGE 13
`define STW_CURRENT 14
`define STW_THERMAL 15

// ==========================================================================
// reset values
// ==========================================================================
`define WORD_RESET 16'h0000
`define BIT_RESET 1'h0

`endif

// ---- inc/drive_bus_data_map_pkg.sv ----
/*
 * Types shared by the drive bus data map files.
 * Assumes nothing of its surroundings.
 */
package drive_bus_data_map_pkg;
   // ========================================================================
   // holding register access sequencer
   // ========================================================================
   typedef enum logic [0:0] {
      ACC_IDLE = 1'b0,   // ready for the next register request
      ACC_PARAM = 1'b1   // waiting on the parameter store
   } access_state_t;

   typedef logic [15:0] word_t;   // one holding register
endpackage : drive_bus_data_map_pkg

// ---- verilog/map_addr_decode.sv ----
/*
 * Address decoder for the coil and holding register spaces.
 * Assumes message addresses are already zero-based and come from logic on
 * the same clock; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "drive_bus_data_map_cfg.svh"

module map_addr_decode
   import drive_bus_data_map_pkg::*;
(
   input wire logic [15:0] i_coil_addr,
   input wire logic [15:0] i_reg_addr,
   output logic o_coil_ctw,
   output logic o_coil_ref,
   output logic o_coil_stw,
   output logic o_coil_mav,
   output logic o_coil_store,
   output logic o_reg_err,
   output logic o_reg_idx,
   output logic o_reg_ctw,
   output logic o_reg_ref,
   output logic o_reg_stw,
   output logic o_reg_mav,
   output logic o_reg_param,
   output logic [15:0] o_param_num
);
   // ========================================================================
   // coil space: one 16-coil field per word, then the storage coil
   // ========================================================================
   // low nibble picks the bit, the rest picks the word
   wire [15:0] coil_field = i_coil_addr & `COIL_FIELD_MASK;   // [RULE_02]
   assign o_coil_ctw = coil_field == `COIL_CTW_BASE;
   assign o_coil_ref = coil_field == `COIL_REF_BASE;
   assign o_coil_stw = coil_field == `COIL_STW_BASE;
   assign o_coil_mav = coil_field == `COIL_MAV_BASE;
   assign o_coil_store = i_coil_addr == `COIL_STORE;

   // ========================================================================
   // holding register space
   // ========================================================================
   assign o_reg_err = i_reg_addr == `REG_LAST_ERROR;   // [RULE_03]
   assign o_reg_idx = i_reg_addr == `REG_ARRAY_INDEX;
   assign o_reg_ctw = i_reg_addr == `REG_CTW;
   assign o_reg_ref = i_reg_addr == `REG_REF;
   assign o_reg_stw = i_reg_addr == `REG_STW;
   assign o_reg_mav = i_reg_addr == `REG_MAV;

   // parameters sit at ten times their number; a constant divide is cheap
   // enough here and keeps the window exact at both ends
   wire [15:0] param_rem = i_reg_addr % `PARAM_STEP;
   assign o_param_num = i_reg_addr / `PARAM_STEP;
   assign o_reg_param = (i_reg_addr >= `PARAM_ADDR_MIN) &&
                        (i_reg_addr <= `PARAM_ADDR_MAX) &&
                        (param_rem == `PARAM_REM_ZERO);   // [RULE_13]
endmodule : map_addr_decode

`default_nettype wire

// ---- tb/param_store_model.sv ----
/* parameter store model answering the map after a commanded wait
   assumes the map's clock and one request at a time */
`timescale 1ns/1ps
`default_nettype none
module param_store_model (
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic [15:0] i_num,
   input wire logic [3:0] i_delay,
   output logic o_ack,
   output logic [15:0] o_rdata
);
   logic [3:0] cnt_reg = 4'h0; // cycles left, 0 when idle
   initial o_rdata = 16'h1234;
   // ==================================================================
   // answer; data toggles outside the ack cycle so stale reads show
   always @(posedge i_clk) begin
      o_ack <= 1'h0;
      o_rdata <= ~o_rdata;
      if (i_req) begin
         cnt_reg <= i_delay + 4'h1;
      end else if (cnt_reg == 4'h1) begin
         cnt_reg <= 4'h0;
         o_ack <= 1'h1;
         o_rdata <= i_num ^ 16'h5a5a;
      end else if (cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end
endmodule : param_store_model
`default_nettype wire

// ---- tb/tb.sv ----
/* random and corner-case bench of the drive bus data map
   assumes the parameter store model on the same clock */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic i_clk = 1'h0, i_reset_n = 1'h0, i_coil_req = 1'h0, i_coil_we = 1'h0;
   logic i_coil_wdata = 1'h0, i_reg_req = 1'h0, i_reg_we = 1'h0;
   logic i_error_strobe = 1'h0, i_param_ack;
   logic [15:0] i_coil_addr = '0, i_reg_addr = '0, i_reg_wdata = '0;
   logic [15:0] i_error_code = '0, i_main_actual = '0, i_param_rdata;
   logic [11:0] st = '0; // drive state levels, control ready first
   logic [3:0] dly = '0; // store wait, varied for prompt and slow answers
   logic o_coil_ack, o_coil_rdata, o_reg_ack, o_reg_busy, o_param_req;
   logic o_param_we, o_store_eeprom, o_dc_brake_req, o_coast_req, o_jog;
   logic o_quick_stop_req, o_freeze_req, o_start, o_reset_req, o_ramp2;
   logic o_data_valid, o_relay1, o_relay2, o_reverse;
   logic [1:0] o_preset_ref, o_setup_sel;
   logic [15:0] o_reg_rdata, o_param_num, o_param_wdata, o_param_index;
   logic [15:0] o_control_word, o_speed_reference, w, r, s, a;
   logic [15:0] rsv [8] = '{16'h0001, 16'h0006, 16'h0008, 16'h006b,
      16'h000b, 16'hc364, 16'h003e, 16'hffbf}; // unmapped places
   int num_errors = 0, samples_checked = 0, cycles = 0;
   always #5 i_clk = ~i_clk;
   drive_bus_data_map drive_bus_data_map_i (.i_clk, .i_reset_n, .i_coil_req,
      .i_coil_we, .i_coil_addr, .i_coil_wdata, .o_coil_ack, .o_coil_rdata,
      .i_reg_req, .i_reg_we, .i_reg_addr, .i_reg_wdata, .o_reg_ack,
      .o_reg_rdata, .o_reg_busy, .o_param_req, .o_param_we, .o_param_num,
      .o_param_wdata, .o_param_index, .o_store_eeprom, .i_param_ack,
      .i_param_rdata, .i_error_strobe, .i_error_code, .i_main_actual,
      .i_control_ready(st[0]), .i_drive_ready(st[1]),
      .i_safety_closed(st[2]), .i_alarm(st[3]), .i_warning(st[4]),
      .i_at_reference(st[5]), .i_auto_mode(st[6]), .i_in_freq_range(st[7]),
      .i_running(st[8]), .i_voltage_warning(st[9]),
      .i_current_limit(st[10]), .i_thermal_warning(st[11]),
      .o_control_word, .o_speed_reference, .o_preset_ref, .o_dc_brake_req,
      .o_coast_req, .o_quick_stop_req, .o_freeze_req, .o_start,
      .o_reset_req, .o_jog, .o_ramp2, .o_data_valid, .o_relay1, .o_relay2,
      .o_setup_sel, .o_reverse);
   param_store_model param_store_model_i (.i_clk, .i_req(o_param_req),
      .i_num(o_param_num), .i_delay(dly), .o_ack(i_param_ack),
      .o_rdata(i_param_rdata));
   // ==================================================================
   // expectations and checks
   function automatic logic [15:0] drive_status_word(input logic [11:0] v);
      return {v[11:9], 1'h0, v[8:4], 3'h0, v[3:0]};
   endfunction : drive_status_word
   // decoded outputs regathered as a word; stop requests are inverted
   function automatic logic [15:0] dec();
      return {o_reverse, o_setup_sel, o_relay2, o_relay1, o_data_valid,
         o_ramp2, o_jog, o_reset_req, o_start, ~o_freeze_req,
         ~o_quick_stop_req, ~o_coast_req, ~o_dc_brake_req, o_preset_ref};
   endfunction : dec
   task automatic chk(input string n, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask : chk
   // one coil access; the answer stands only in the cycle after it
   task automatic coil(input logic we, input logic [15:0] ad,
         input logic d, e);
      @(posedge i_clk);
      i_coil_req <= 1'h1;
      i_coil_we <= we;
      i_coil_addr <= ad;
      i_coil_wdata <= d;
      @(posedge i_clk);
      i_coil_req <= 1'h0;
      #1 chk("coil_ack", 16'h1, {15'h0, o_coil_ack});
      if (!we) chk("coil_rdata", {15'h0, e}, {15'h0, o_coil_rdata});
   endtask : coil
   // one register access; parameter places answer late, so wait bounded
   task automatic rg(input logic we, input logic [15:0] ad, d, e);
      int n = 0;
      @(posedge i_clk);
      i_reg_req <= 1'h1;
      i_reg_we <= we;
      i_reg_addr <= ad;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_req <= 1'h0;
      #1;
      while (o_reg_ack !== 1'h1 && n < 40) begin
         @(posedge i_clk);
         #1 n++;
      end
      chk("reg_ack", 16'h1, {15'h0, o_reg_ack});
      if (!we) chk("reg_rdata", e, o_reg_rdata);
   endtask : rg
   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // hang guard, far above the several hundred cycles the run needs
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   // ==================================================================
   // main sequence: corners first, then random words
   initial begin
      void'($urandom(59783));
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'h1;
      repeat (2) @(posedge i_clk);
      #1 chk("reset_decode", 16'h0, dec());
      for (int k = 0; k < 6; k++) begin
         w = k == 0 ? 16'hffff : k == 1 ? 16'h0 : 16'($urandom);
         r = 16'($urandom);
         a = 16'($urandom_range(15));
         rg(1'h1, 16'hc350, w, 16'h0);
         repeat (2) @(posedge i_clk);
         #1 chk("decoded", w, dec());
         coil(1'h0, a, 1'h0, w[a]);
         w[a] = ~w[a];
         coil(1'h1, a, w[a], 1'h0);
         rg(1'h0, 16'hc350, 16'h0, w);
         rg(1'h1, 16'hc35a, r, 16'h0);
         chk("speed_ref", r, o_speed_reference);
         for (int b = 0; b < 16; b++)
            coil(1'h0, 16'(16 + b), 1'h0, r[b]);
         @(posedge i_clk);
         st <= 12'($urandom);
         i_main_actual <= r ^ 16'h00ff;
         i_error_code <= r ^ w;
         i_error_strobe <= 1'h1;
         dly <= 4'(k * 2);
         @(posedge i_clk);
         i_error_strobe <= 1'h0;
         repeat (2) @(posedge i_clk);
         s = drive_status_word(st);
         rg(1'h1, 16'hc418, 16'hffff, 16'h0);
         rg(1'h0, 16'hc418, 16'h0, s);
         coil(1'h0, 16'(32 + a), 1'h0, s[a]);
         rg(1'h0, 16'hc422, 16'h0, r ^ 16'h00ff);
         coil(1'h1, 16'h0040, w[0], 1'h0);
         coil(1'h0, 16'h0040, 1'h0, w[0]);
         chk("store", {15'h0, w[0]}, {15'h0, o_store_eeprom});
         rg(1'h1, 16'h0007, w, 16'h0);
         rg(1'h0, 16'h0007, 16'h0, r ^ w);
         rg(1'h1, 16'h0009, s, 16'h0);
         chk("index", s, o_param_index);
         a = k == 0 ? 16'h000a : k == 1 ? 16'hc346 :
            16'(10 * $urandom_range(1, 4999));
         rg(1'h0, a, 16'h0, (a / 16'h000a) ^ 16'h5a5a);
         rg(1'h1, a, r, 16'h0);
         chk("param_num", a / 16'h000a, o_param_num);
         chk("param_wdata", r, o_param_wdata);
         chk("param_we", 16'h1, {15'h0, o_param_we});
      end
      foreach (rsv[i]) begin
         rg(1'h1, rsv[i], 16'hffff, 16'h0);
         rg(1'h0, rsv[i], 16'h0, 16'h0);
         coil(1'h1, rsv[i] + 16'h0040, 1'h1, 1'h0);
         coil(1'h0, rsv[i] + 16'h0040, 1'h0, 1'h0);
      end
      rg(1'h0, 16'hc350, 16'h0, w);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
